// File: rtl/uair_defines.svh
// Offsets, field positions, reset values and timing for the USB address and interrupt registers.
// Assumes a 10 MHz pclk and a 32-bit APB slave decoding byte addresses.
`ifndef UAIR_DEFINES_SVH
`define UAIR_DEFINES_SVH

`define UAIR_ADDR_W 8
`define UAIR_OFF_FADDR 8'h08
`define UAIR_OFF_IER 8'h10
`define UAIR_OFF_IDR 8'h14
`define UAIR_OFF_IMR 8'h18
`define UAIR_OFF_ISR 8'h1c
`define UAIR_OFF_ICR 8'h20

`define UAIR_FADDR_MSB 6
`define UAIR_FEN_BIT 8
`define UAIR_FADDR_RST 7'h00
`define UAIR_FEN_RST 1'h1

`define UAIR_EP_MSB 5
`define UAIR_SUSP_BIT 8
`define UAIR_HRSM_BIT 9
`define UAIR_XRSM_BIT 10
`define UAIR_SOF_BIT 11
`define UAIR_BRST_BIT 12
`define UAIR_WAKE_BIT 13

`define UAIR_MASK_RW 32'h0000_2f3f
`define UAIR_MASK_FIXED 32'h0000_1000
`define UAIR_MASK_RST 32'h0000_0200
`define UAIR_EVT_BITS 32'h0000_3f00
`define UAIR_ZERO 32'h0000_0000

`define UAIR_CLK_MHZ 10
`define UAIR_IDLE_US 3000
`define UAIR_IDLE_CYCLES (`UAIR_IDLE_US * `UAIR_CLK_MHZ)

`endif

// File: rtl/uair_pkg.sv
// Types shared by the USB address and interrupt register block.
// Assumes the constants of uair_defines.svh.
package uair_pkg;
   typedef enum logic {
      UAIR_BUS_ACTIVE,
      UAIR_BUS_SUSPENDED
   } uair_link_e;
   typedef logic [31:0] uair_word_t;
endpackage

// File: rtl/uair_regs.sv
// Function address, interrupt mask and interrupt status registers of a USB device port, as an APB slave.
// Assumes endpoint flags arrive on pclk; bus events arrive as levels from the USB side and are synchronised.
//
// Notes on behaviour
// - Seven-bit address, zero after reset
// - Function enable at bit 8, readable
// - Endpoints move data only while function enabled
// - Enable register: ones set mask bits
// - Disable register: ones clear mask bits
// - Mask register shows enabled sources
// - Shared layout: endpoints 0-5, events 8-13
// - Host resume enabled in mask after reset
// - Endpoint status is OR of its flags
// - Endpoint status clears only with its flags
// - Status bit high once source raised
// - Three milliseconds idle sets suspend, enters suspend
// - Start-of-frame token sets its status bit
// - Bus reset end sets bit 12
// - Clear register: ones clear event status bits
`include "uair_defines.svh"

module uair_regs #(
   parameter int unsigned IDLE_CYCLES = `UAIR_IDLE_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`UAIR_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [5:0] setup_received,
   input wire logic [5:0] bank0_received,
   input wire logic [5:0] bank1_received,
   input wire logic [5:0] in_transfer_done,
   input wire logic [5:0] stall_handshake_sent,
   input wire logic bus_activity,
   input wire logic sof_token,
   input wire logic host_resume,
   input wire logic bus_reset_end,
   input wire logic ext_resume_pin,
   output logic [6:0] device_addr_value,
   output logic function_enable,
   output logic usb_suspended,
   output logic irq
);
   localparam int unsigned CW = $clog2(IDLE_CYCLES + 1);
   localparam logic [CW-1:0] IDLE_LAST = CW'(IDLE_CYCLES - 1);

   // Synchronised bus-side levels and their previous values for edge detection
   logic [4:0] bus_sync;
   logic [4:0] bus_prev;
   logic [4:0] next_bus_prev;
   logic act_lvl;
   logic sof_rise;
   logic hrsm_rise;
   logic brst_rise;
   logic xrsm_rise;

   uair_sync #(
      .W(5)
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d({ext_resume_pin, bus_reset_end, host_resume, sof_token, bus_activity}),
      .q(bus_sync)
   );

   always_comb begin
      next_bus_prev = bus_sync;
      act_lvl = bus_sync[0];
      sof_rise = bus_sync[1] & ~bus_prev[1];
      hrsm_rise = bus_sync[2] & ~bus_prev[2];
      brst_rise = bus_sync[3] & ~bus_prev[3];
      xrsm_rise = bus_sync[4] & ~bus_prev[4];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_prev <= '0;
      end else begin
         bus_prev <= next_bus_prev;
      end
   end

   // APB decode; the answer comes one cycle into the access phase
   logic wr_fire;
   logic next_pready;
   logic next_pslverr;
   logic [31:0] next_prdata;
   logic hit;
   logic [31:0] rd_word;
   logic [31:0] mask;
   logic [31:0] status;

   always_comb begin
      wr_fire = psel & penable & pready & pwrite;
      next_pready = psel & penable & ~pready;
      hit = 1'b1;
      rd_word = `UAIR_ZERO;
      unique case (paddr)
         `UAIR_OFF_FADDR: begin
            rd_word[`UAIR_FADDR_MSB:0] = device_addr_value;
            rd_word[`UAIR_FEN_BIT] = function_enable;
         end
         `UAIR_OFF_IMR: rd_word = mask | `UAIR_MASK_FIXED;
         `UAIR_OFF_ISR: rd_word = status;
         // Write-only registers read as zero without error
         `UAIR_OFF_IER, `UAIR_OFF_IDR, `UAIR_OFF_ICR: rd_word = `UAIR_ZERO;
         default: hit = 1'b0;
      endcase
      next_prdata = prdata;
      next_pslverr = pslverr;
      if (next_pready) begin
         next_prdata = pwrite ? `UAIR_ZERO : rd_word;
         next_pslverr = ~hit;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= `UAIR_ZERO;
      end else begin
         pready <= next_pready;
         pslverr <= next_pslverr;
         prdata <= next_prdata;
      end
   end

   // Function address and enable
   logic [6:0] next_addr;
   logic next_fen;

   always_comb begin
      next_addr = device_addr_value;
      next_fen = function_enable;
      if (wr_fire && paddr == `UAIR_OFF_FADDR) begin
         next_addr = pwdata[`UAIR_FADDR_MSB:0];
         next_fen = pwdata[`UAIR_FEN_BIT];
      end
   end

   // The endpoint engines gate their packet traffic on this output
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         device_addr_value <= `UAIR_FADDR_RST;
         function_enable <= `UAIR_FEN_RST;
      end else begin
         device_addr_value <= next_addr;
         function_enable <= next_fen;
      end
   end

   // Interrupt mask
   logic [31:0] next_mask;
   logic [31:0] set_bits;
   logic [31:0] clr_bits;

   always_comb begin
      set_bits = (wr_fire && paddr == `UAIR_OFF_IER) ? pwdata : `UAIR_ZERO;
      clr_bits = (wr_fire && paddr == `UAIR_OFF_IDR) ? pwdata : `UAIR_ZERO;
      // Unused positions never reach the mask
      next_mask = ((mask | set_bits) & ~clr_bits) & `UAIR_MASK_RW;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask <= `UAIR_MASK_RST;
      end else begin
         mask <= next_mask;
      end
   end

   // Suspend detection: idle time counted in pclk cycles
   uair_pkg::uair_link_e link_st;
   uair_pkg::uair_link_e next_link_st;
   logic [CW-1:0] idle_cnt;
   logic [CW-1:0] next_idle_cnt;
   logic susp_enter;
   logic next_suspended;

   always_comb begin
      next_link_st = link_st;
      next_idle_cnt = idle_cnt;
      susp_enter = 1'b0;
      unique case (link_st)
         uair_pkg::UAIR_BUS_ACTIVE: begin
            if (act_lvl) begin
               next_idle_cnt = '0;
            end else if (idle_cnt == IDLE_LAST) begin
               next_link_st = uair_pkg::UAIR_BUS_SUSPENDED;
               next_idle_cnt = '0;
               susp_enter = 1'b1;
            end else begin
               next_idle_cnt = idle_cnt + CW'(1);
            end
         end
         uair_pkg::UAIR_BUS_SUSPENDED: begin
            // Host traffic, host resume or bus reset wakes the port
            if (act_lvl | hrsm_rise | brst_rise) begin
               next_link_st = uair_pkg::UAIR_BUS_ACTIVE;
            end
         end
      endcase
      next_suspended = (next_link_st == uair_pkg::UAIR_BUS_SUSPENDED);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link_st <= uair_pkg::UAIR_BUS_ACTIVE;
         idle_cnt <= '0;
         usb_suspended <= 1'b0;
      end else begin
         link_st <= next_link_st;
         idle_cnt <= next_idle_cnt;
         usb_suspended <= next_suspended;
      end
   end

   // Interrupt status: endpoint bits follow their flags, event bits are sticky
   logic [31:0] next_status;
   logic [31:0] ev;
   logic [31:0] ack;
   logic [5:0] ep_any;

   always_comb begin
      ep_any = setup_received | bank0_received | bank1_received | in_transfer_done | stall_handshake_sent;
      ev = `UAIR_ZERO;
      ev[`UAIR_SUSP_BIT] = susp_enter;
      ev[`UAIR_HRSM_BIT] = hrsm_rise;
      // External resume only counts while suspended
      ev[`UAIR_XRSM_BIT] = xrsm_rise & usb_suspended;
      ev[`UAIR_SOF_BIT] = sof_rise;
      ev[`UAIR_BRST_BIT] = brst_rise;
      ev[`UAIR_WAKE_BIT] = hrsm_rise | brst_rise | (xrsm_rise & usb_suspended);
      ack = (wr_fire && paddr == `UAIR_OFF_ICR) ? pwdata : `UAIR_ZERO;
      // A new event in the clearing cycle survives the clear
      next_status = ((status & ~ack) | ev) & `UAIR_EVT_BITS;
      next_status[`UAIR_EP_MSB:0] = ep_any;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status <= `UAIR_ZERO;
      end else begin
         status <= next_status;
      end
   end

   logic next_irq;

   always_comb begin
      next_irq = |(status & (mask | `UAIR_MASK_FIXED));
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= next_irq;
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   addr_write_a: assert property (
      wr_fire && paddr == `UAIR_OFF_FADDR |=> device_addr_value == $past(pwdata[`UAIR_FADDR_MSB:0])
         && function_enable == $past(pwdata[`UAIR_FEN_BIT]))
      else $error("function address or enable not taken from write");

   addr_hold_a: assert property (
      !(wr_fire && paddr == `UAIR_OFF_FADDR) |=> $stable(device_addr_value) && $stable(function_enable))
      else $error("function address changed without a write");

   mask_set_a: assert property (
      wr_fire && paddr == `UAIR_OFF_IER |=> (mask & ($past(pwdata) & `UAIR_MASK_RW))
         == ($past(pwdata) & `UAIR_MASK_RW))
      else $error("enable write did not set mask bits");

   mask_clear_a: assert property (
      wr_fire && paddr == `UAIR_OFF_IDR |=> (mask & $past(pwdata)) == `UAIR_ZERO)
      else $error("disable write did not clear mask bits");

   mask_view_a: assert property (
      next_pready && !pwrite && paddr == `UAIR_OFF_IMR |=> prdata == (mask | `UAIR_MASK_FIXED))
      else $error("mask read returned wrong value");

   unused_zero_a: assert property (
      (status & ~(`UAIR_EVT_BITS | 32'h0000_003f)) == `UAIR_ZERO
         && (mask & ~`UAIR_MASK_RW) == `UAIR_ZERO)
      else $error("unused bit set in mask or status");

   ep_follow_a: assert property (
      ##1 status[5:0] == $past(ep_any))
      else $error("endpoint status does not follow its flags");

   sof_sticky_a: assert property (
      sof_rise |=> status[`UAIR_SOF_BIT] [*2])
      else $error("frame start status not held");

   susp_time_a: assert property (
      link_st == uair_pkg::UAIR_BUS_ACTIVE && idle_cnt == IDLE_LAST && !act_lvl
         |=> status[`UAIR_SUSP_BIT] && usb_suspended)
      else $error("suspend not entered after idle time");

   brst_set_a: assert property (
      brst_rise |=> status[`UAIR_BRST_BIT] && status[`UAIR_WAKE_BIT])
      else $error("bus reset end not flagged");

   icr_clear_a: assert property (
      wr_fire && paddr == `UAIR_OFF_ICR && pwdata[`UAIR_SOF_BIT]
         && !sof_rise |=> !status[`UAIR_SOF_BIT])
      else $error("clear write left frame start status set");

   irq_level_a: assert property (
      |(status & (mask | `UAIR_MASK_FIXED)) |=> irq)
      else $error("interrupt not raised for enabled status");

   irq_quiet_a: assert property (
      (status & (mask | `UAIR_MASK_FIXED)) == `UAIR_ZERO |=> !irq)
      else $error("interrupt raised with no enabled status");

   apb_answer_a: assert property (
      psel && penable && !pready |=> pready ##1 !pready)
      else $error("APB answer not one cycle into access");
endmodule

// File: rtl/uair_sync.sv
// Two-stage synchroniser for a group of independent level inputs.
// Assumes each input is a level held for at least two pclk cycles.
module uair_sync #(
   parameter int unsigned W = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;
   logic [W-1:0] next_meta;
   logic [W-1:0] next_q;

   always_comb begin
      next_meta = d;
      next_q = meta;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= next_meta;
         q <= next_q;
      end
   end
endmodule

// File: testbench/uair_host_model.sv
// Stand-in for the USB host: drives the bus-side event levels and the activity level.
// Assumes the bench calls its tasks from one process only.
module uair_host_model (
   input wire logic pclk,
   output logic sof_token,
   output logic host_resume,
   output logic bus_reset_end,
   output logic ext_resume_pin,
   output logic bus_activity
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] ln = 4'h0;
   // Lines rest low between events, so a later event is always a fresh rising edge
   assign {ext_resume_pin, bus_reset_end, host_resume, sof_token} = ln;
   logic act = 1'b1;
   assign bus_activity = act;
   // Three cycles high and three low, beyond the two-cycle synchroniser minimum
   task automatic ev(input int n);
      @(posedge pclk);
      ln <= ln | (4'h1 << n);
      repeat (3) @(posedge pclk);
      ln <= ln & ~(4'h1 << n);
      repeat (3) @(posedge pclk);
   endtask
   task automatic traffic(input logic on);
      @(posedge pclk);
      act <= on;
   endtask
endmodule

// File: testbench/usb_device_addr_irq_regs_tb_top.sv
// Self-checking bench for the address and interrupt registers, with integer models of mask and status.
// Assumes the register block with a 20-cycle idle limit and the host stand-in.
module usb_device_addr_irq_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic pready, pslverr, e, function_enable, usb_suspended, irq;
   logic sof_token, host_resume, bus_reset_end, ext_resume_pin, bus_activity;
   logic [5:0] fl [5] = '{default: 6'h00};
   logic [6:0] device_addr_value;
   int failures = 0, n_compared = 0, n;
   logic [31:0] mask = 32'h200, st = 32'h0, ep = 32'h0, a;
   always #50 pclk = ~pclk;
   uair_regs #(.IDLE_CYCLES(20)) u_uair_regs (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .setup_received(fl[0]), .bank0_received(fl[1]),
      .bank1_received(fl[2]), .in_transfer_done(fl[3]), .stall_handshake_sent(fl[4]),
      .bus_activity(bus_activity), .sof_token(sof_token), .host_resume(host_resume),
      .bus_reset_end(bus_reset_end), .ext_resume_pin(ext_resume_pin),
      .device_addr_value(device_addr_value), .function_enable(function_enable),
      .usb_suspended(usb_suspended), .irq(irq));
   uair_host_model u_uair_host_model (.pclk(pclk), .sof_token(sof_token), .host_resume(host_resume),
      .bus_reset_end(bus_reset_end), .ext_resume_pin(ext_resume_pin), .bus_activity(bus_activity));
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Request held from setup until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 20) begin
         failures++;
         complete_run();
      end
   endtask
   task automatic rd(input logic [7:0] ad, input logic [31:0] exp);
      apb(1'b0, ad, 32'h0);
      chk(r, exp);
   endtask
   // Status read, then the interrupt line against the masked model
   task automatic look();
      logic [31:0] x;
      x = {31'h0, ((st | ep) & (mask | 32'h1000)) != 32'h0};
      rd(8'h1c, st | ep);
      chk({31'h0, irq}, x);
   endtask
   initial begin
      a = $urandom(60335);
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rd(8'h08, 32'h100);
      rd(8'h18, 32'h1200);
      rd(8'h1c, 32'h0);
      rd(8'h10, 32'h0);
      apb(1'b0, 8'h0c, 32'h0);
      chk({31'h0, e}, 32'h1);
      $display("test reset done");
      u_uair_host_model.ev(2);
      st = 32'h3000;
      look();
      a = $urandom;
      apb(1'b1, 8'h08, a);
      rd(8'h08, a & 32'h17f);
      chk({25'h0, device_addr_value}, a & 32'h7f);
      chk({31'h0, function_enable}, {31'h0, a[8]});
      apb(1'b1, 8'h08, 32'h100);
      @(posedge pclk);
      chk({31'h0, function_enable}, 32'h1);
      apb(1'b1, 8'h1c, 32'hffff_ffff);
      look();
      $display("test address done");
      repeat (8) begin
         a = $urandom;
         apb(1'b1, 8'h10, a);
         mask = (mask | a) & 32'h2f3f;
         rd(8'h18, mask | 32'h1000);
         a = $urandom;
         apb(1'b1, 8'h14, a);
         mask = mask & ~a;
         rd(8'h18, mask | 32'h1000);
      end
      $display("test mask done");
      repeat (4) begin
         fl <= '{6'($urandom), 6'($urandom), 6'($urandom), 6'($urandom), 6'($urandom)};
         @(posedge pclk);
         ep = {26'h0, fl[0] | fl[1] | fl[2] | fl[3] | fl[4]};
         repeat (2) @(posedge pclk);
         look();
         apb(1'b1, 8'h20, 32'h3f);
         look();
      end
      fl <= '{default: 6'h00};
      ep = 32'h0;
      repeat (3) @(posedge pclk);
      look();
      $display("test endpoints done");
      apb(1'b1, 8'h10, 32'h2f3f);
      mask = 32'h2f3f;
      u_uair_host_model.ev(0);
      st |= 32'h800;
      look();
      u_uair_host_model.ev(1);
      st |= 32'h2200;
      look();
      u_uair_host_model.ev(3);
      look();
      apb(1'b1, 8'h14, 32'h2f3f);
      mask = 32'h0;
      look();
      apb(1'b1, 8'h20, 32'hffff_ffff);
      st = 32'h0;
      look();
      apb(1'b1, 8'h10, 32'h0500);
      mask = 32'h0500;
      $display("test events done");
      u_uair_host_model.traffic(1'b0);
      n = 0;
      while (usb_suspended !== 1'b1 && n < 60) begin
         @(posedge pclk);
         n++;
      end
      chk({31'h0, usb_suspended}, 32'h1);
      st = 32'h100;
      look();
      u_uair_host_model.ev(3);
      st |= 32'h2400;
      look();
      u_uair_host_model.traffic(1'b1);
      apb(1'b1, 8'h20, 32'h2500);
      st = 32'h0;
      look();
      chk({31'h0, usb_suspended}, 32'h0);
      $display("test suspend done");
      apb(1'b1, 8'h08, 32'h7f);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      mask = 32'h200;
      st = 32'h0;
      rd(8'h08, 32'h100);
      rd(8'h18, 32'h1200);
      look();
      $display("test second reset done");
      complete_run();
   end
endmodule
